// ### src/dwc_map.svh
`ifndef DWC_MAP_SVH
`define DWC_MAP_SVH

// ****************************************************************
// apb register offsets (byte addresses)
// ****************************************************************
`define DWC_OFF_WIPER_A  8'h00
`define DWC_OFF_WIPER_B  8'h04
`define DWC_OFF_STORED   8'h08
`define DWC_OFF_STATUS   8'h0C
`define DWC_OFF_CTRL     8'h10
`define DWC_OFF_FRAMES   8'h14

// ****************************************************************
// field positions, reset values and fixed address bits
// ****************************************************************
`define DWC_CTRL_EN_BIT  0
`define DWC_ST_WP_BIT    0
`define DWC_ST_INIT_BIT  1
`define DWC_ST_BAD_BIT   2
`define DWC_CTRL_EN_RST  1'h1
`define DWC_NV_FACTORY   8'h80
`define DWC_ADDR_FIXED   4'h5

// ****************************************************************
// link bit-cycle numbers and timing
// ****************************************************************
`define DWC_CYC_ADDR_END 5'h08
`define DWC_CYC_CMD_END  5'h11
`define DWC_CYC_DATA_END 5'h1A
`define DWC_CYC_MAX      5'h1F
`define DWC_CLK_PS       5000
`define DWC_POR_TIME_NS  10000
`define DWC_POR_MAX_CYC  ((`DWC_POR_TIME_NS * 1000) / `DWC_CLK_PS)
`define DWC_INIT_WAIT    2'h3

`endif

// ### src/dwc_pkg.sv
package dwc_pkg;

  // ****************************************************************
  // command operations (upper nibble of the command byte)
  // ****************************************************************
  typedef enum logic [3:0] {
    DWC_OP_WR_VOL    = 4'h1,
    DWC_OP_WR_STORED = 4'h2,
    DWC_OP_SAVE      = 4'h5,
    DWC_OP_RESTORE   = 4'h6
  } dwc_op_t;

  typedef enum logic [1:0] {
    DWC_ST_INIT = 2'b01,
    DWC_ST_RUN  = 2'b10
  } dwc_state_t;

  // ****************************************************************
  // state records
  // ****************************************************************
  typedef struct packed {
    logic [4:0] cnt;
    logic [7:0] shift;
    logic       addr_ok;
    logic       wr;
    logic [7:0] cmd;
    logic [7:0] data;
    logic       done;
  } dwc_link_t;

  typedef struct packed {
    dwc_state_t  st;
    logic [1:0]  init_cnt;
    logic        wp_s1;
    logic        wp_s2;
    logic [2:0]  strap_s1;
    logic [2:0]  strap_s2;
    logic [2:0]  strap;
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_s3;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_s3;
    logic        done_s1;
    logic        done_s2;
    logic        done_s3;
    logic        link_rst;
    logic        arm;
    logic [7:0]  volatile_wiper_reg_a;
    logic [7:0]  volatile_wiper_reg_b;
    logic        ctrl_en;
    logic        bad_cmd;
    logic [7:0]  frames;
    logic [31:0] prdata;
    logic        pslverr;
  } dwc_core_t;

endpackage

// ### src/dwc_link.sv
`include "dwc_map.svh"

module dwc_link (
  input  wire logic       scl,
  input  wire logic       link_rst,
  input  wire logic       sda_i,
  input  wire logic [2:0] strap,
  output logic            sda_oe,
  output logic            done,
  output logic [7:0]      cmd,
  output logic [7:0]      data
);

  dwc_pkg::dwc_link_t r_r;
  dwc_pkg::dwc_link_t r_nxt;
  logic               oe_r;

  // ****************************************************************
  // bit shifter on the link clock
  // ****************************************************************
  always_comb begin
    logic [4:0] nc;
    logic [7:0] sh8;
    nc = r_r.cnt;
    sh8 = {r_r.shift[6:0], sda_i};
    r_nxt = r_r;
    if (r_r.cnt != `DWC_CYC_MAX) begin
      nc = r_r.cnt + 5'h01;
    end
    r_nxt.cnt = nc;
    r_nxt.shift = sh8;
    if (nc == `DWC_CYC_ADDR_END) begin
      r_nxt.addr_ok = (sh8[7:1] == {`DWC_ADDR_FIXED, strap});
      r_nxt.wr = ~sh8[0];
    end
    if (nc == `DWC_CYC_CMD_END) begin
      r_nxt.cmd = sh8;
    end
    if (nc == `DWC_CYC_DATA_END) begin
      r_nxt.data = sh8;
      r_nxt.done = r_r.addr_ok & r_r.wr;
    end
  end

  // frame state is cleared by start and stop, so a partial frame is lost
  always_ff @(posedge scl or posedge link_rst) begin
    if (link_rst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ack is driven from the falling edge so sda is steady while scl is high
  always_ff @(negedge scl or posedge link_rst) begin
    if (link_rst) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= r_r.addr_ok && ((r_r.cnt == `DWC_CYC_ADDR_END) ||
              (r_r.cnt == `DWC_CYC_CMD_END) ||
              (r_r.cnt == `DWC_CYC_DATA_END));
    end
  end

  assign sda_oe = oe_r;
  assign done   = r_r.done;
  assign cmd    = r_r.cmd;
  assign data   = r_r.data;

endmodule // dwc_link

// ### src/dwc_decoder.sv
`include "dwc_map.svh"

module dwc_decoder (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        write_protect,
  input  wire logic        addr_strap_2,
  input  wire logic        addr_strap_1,
  input  wire logic        addr_strap_0,
  input  wire logic        factory_rst_n,
  output logic [7:0]       wiper_a,
  output logic [7:0]       wiper_b
);

  // ****************************************************************
  // per-channel command effect
  // ****************************************************************
  // returns {stored write enable, new volatile, new stored}
  function automatic logic [16:0] dwc_apply(
    input logic [3:0] op,
    input logic [7:0] vol,
    input logic [7:0] sto,
    input logic [7:0] dat,
    input logic       wp
  );
    logic [16:0] res;
    res = {1'b0, vol, sto};
    if (op == dwc_pkg::DWC_OP_WR_VOL) begin
      if (wp) begin
        res = {1'b0, sto, sto};
      end else begin
        res = {1'b0, dat, sto};
      end
    end else if (op == dwc_pkg::DWC_OP_RESTORE) begin
      res = {1'b0, sto, sto};
    end else if (op == dwc_pkg::DWC_OP_WR_STORED) begin
      if (!wp) begin
        res = {1'b1, vol, dat};
      end
    end else if (op == dwc_pkg::DWC_OP_SAVE) begin
      if (!wp) begin
        res = {1'b1, vol, vol};
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // command byte decoding
  // ****************************************************************
  // true when the target nibble selects the channel (0 = a, 1 = b)
  function automatic logic dwc_tgt_hit(
    input logic [3:0] tgt,
    input logic       ch_b
  );
    logic hit;
    hit = 1'b0;
    if (tgt == 4'h3) begin
      hit = 1'b1;
    end else if (ch_b) begin
      hit = (tgt == 4'h2);
    end else begin
      hit = (tgt == 4'h1);
    end
    return hit;
  endfunction

  // true only for the four operation codes that are carried out
  function automatic logic dwc_op_known(
    input logic [3:0] op
  );
    logic known;
    known = 1'b0;
    if ((op == dwc_pkg::DWC_OP_WR_VOL) ||
        (op == dwc_pkg::DWC_OP_WR_STORED)) begin
      known = 1'b1;
    end else if ((op == dwc_pkg::DWC_OP_SAVE) ||
                 (op == dwc_pkg::DWC_OP_RESTORE)) begin
      known = 1'b1;
    end
    return known;
  endfunction

  // status word: protect level, init done, last command bad
  function automatic logic [31:0] dwc_status_word(
    input logic wp,
    input logic init_done,
    input logic bad
  );
    logic [31:0] word;
    word = 32'h0000_0000;
    word[`DWC_ST_WP_BIT] = wp;
    word[`DWC_ST_INIT_BIT] = init_done;
    word[`DWC_ST_BAD_BIT] = bad;
    return word;
  endfunction

  dwc_pkg::dwc_core_t r_r;
  dwc_pkg::dwc_core_t r_nxt;
  logic [7:0]         stored_wiper_reg_a_r;
  logic [7:0]         stored_wiper_reg_b_r;
  logic [7:0]         stored_a_nxt;
  logic [7:0]         stored_b_nxt;
  logic               link_done;
  logic [7:0]         link_cmd;
  logic [7:0]         link_data;
  logic               link_oe;

  // ****************************************************************
  // link-clock shifter
  // ****************************************************************
  dwc_link u_link (
    .scl      (scl),
    .link_rst (r_r.link_rst),
    .sda_i    (sda_i),
    .strap    (r_r.strap),
    .sda_oe   (link_oe),
    .done     (link_done),
    .cmd      (link_cmd),
    .data     (link_data)
  );

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    logic        start;
    logic        stop;
    logic        exec;
    logic        tgt_a;
    logic        tgt_b;
    logic        op_ok;
    logic [16:0] ea;
    logic [16:0] eb;
    start = 1'b0;
    stop = 1'b0;
    exec = 1'b0;
    tgt_a = 1'b0;
    tgt_b = 1'b0;
    op_ok = 1'b0;
    ea = '0;
    eb = '0;
    r_nxt = r_r;
    stored_a_nxt = stored_wiper_reg_a_r;
    stored_b_nxt = stored_wiper_reg_b_r;

    // pin and link done synchronisers
    r_nxt.wp_s1 = write_protect;
    r_nxt.wp_s2 = r_r.wp_s1;
    r_nxt.strap_s1 = {addr_strap_2, addr_strap_1, addr_strap_0};
    r_nxt.strap_s2 = r_r.strap_s1;
    r_nxt.scl_s1 = scl;
    r_nxt.scl_s2 = r_r.scl_s1;
    r_nxt.scl_s3 = r_r.scl_s2;
    r_nxt.sda_s1 = sda_i;
    r_nxt.sda_s2 = r_r.sda_s1;
    r_nxt.sda_s3 = r_r.sda_s2;
    r_nxt.done_s1 = link_done;
    r_nxt.done_s2 = r_r.done_s1;
    r_nxt.done_s3 = r_r.done_s2;

    // start and stop seen while scl is high
    start = r_r.scl_s2 & r_r.scl_s3 & r_r.sda_s3 & ~r_r.sda_s2;
    stop  = r_r.scl_s2 & r_r.scl_s3 & ~r_r.sda_s3 & r_r.sda_s2;
    r_nxt.arm = start;
    if (start || stop) begin
      r_nxt.link_rst = 1'b1;
    end else if (r_r.arm) begin
      r_nxt.link_rst = 1'b0;
    end

    case (r_r.st)
      dwc_pkg::DWC_ST_INIT: begin
        // wait only for the synchronisers, far inside the 10 us budget
        r_nxt.init_cnt = r_r.init_cnt + 2'h1;
        if (r_r.init_cnt == `DWC_INIT_WAIT) begin
          r_nxt.strap = r_r.strap_s2;
          r_nxt.volatile_wiper_reg_a = stored_wiper_reg_a_r;
          r_nxt.volatile_wiper_reg_b = stored_wiper_reg_b_r;
          r_nxt.st = dwc_pkg::DWC_ST_RUN;
        end
      end
      dwc_pkg::DWC_ST_RUN: begin
        // cmd and data hold still while done is high, so no bus skew
        exec = r_r.done_s2 & ~r_r.done_s3 & r_r.ctrl_en;
      end
      default: begin
        r_nxt.st = dwc_pkg::DWC_ST_INIT;
      end
    endcase

    if (exec) begin
      tgt_a = dwc_tgt_hit(link_cmd[3:0], 1'b0);
      tgt_b = dwc_tgt_hit(link_cmd[3:0], 1'b1);
      op_ok = dwc_op_known(link_cmd[7:4]);
      r_nxt.bad_cmd = ~op_ok | ~(tgt_a | tgt_b);
      r_nxt.frames = r_r.frames + 8'h01;
      ea = dwc_apply(link_cmd[7:4], r_r.volatile_wiper_reg_a,
                     stored_wiper_reg_a_r, link_data, r_r.wp_s2);
      eb = dwc_apply(link_cmd[7:4], r_r.volatile_wiper_reg_b,
                     stored_wiper_reg_b_r, link_data, r_r.wp_s2);
      if (tgt_a) begin
        r_nxt.volatile_wiper_reg_a = ea[15:8];
        if (ea[16]) begin
          stored_a_nxt = ea[7:0];
        end
      end
      if (tgt_b) begin
        r_nxt.volatile_wiper_reg_b = eb[15:8];
        if (eb[16]) begin
          stored_b_nxt = eb[7:0];
        end
      end
    end

    // apb: read data captured in setup, write taken in access
    r_nxt.prdata = 32'h0000_0000;
    r_nxt.pslverr = 1'b0;
    if (psel && !penable) begin
      if (paddr == `DWC_OFF_WIPER_A) begin
        r_nxt.prdata = {24'h00_0000, r_r.volatile_wiper_reg_a};
      end else if (paddr == `DWC_OFF_WIPER_B) begin
        r_nxt.prdata = {24'h00_0000, r_r.volatile_wiper_reg_b};
      end else if (paddr == `DWC_OFF_STORED) begin
        r_nxt.prdata = {16'h0000, stored_wiper_reg_b_r,
                        stored_wiper_reg_a_r};
      end else if (paddr == `DWC_OFF_STATUS) begin
        r_nxt.prdata = dwc_status_word(r_r.wp_s2,
                         (r_r.st == dwc_pkg::DWC_ST_RUN), r_r.bad_cmd);
      end else if (paddr == `DWC_OFF_CTRL) begin
        r_nxt.prdata[`DWC_CTRL_EN_BIT] = r_r.ctrl_en;
      end else if (paddr == `DWC_OFF_FRAMES) begin
        r_nxt.prdata = {24'h00_0000, r_r.frames};
      end else begin
        r_nxt.pslverr = 1'b1;
      end
    end else if (psel && penable) begin
      r_nxt.prdata = r_r.prdata;
      r_nxt.pslverr = r_r.pslverr;
      if (pwrite && (paddr == `DWC_OFF_CTRL)) begin
        r_nxt.ctrl_en = pwdata[`DWC_CTRL_EN_BIT];
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '0;
      r_r.st <= dwc_pkg::DWC_ST_INIT;
      r_r.link_rst <= 1'b1;
      r_r.ctrl_en <= `DWC_CTRL_EN_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // stored values ignore presetn so they survive a power cycle
  always_ff @(posedge pclk or negedge factory_rst_n) begin
    if (!factory_rst_n) begin
      stored_wiper_reg_a_r <= `DWC_NV_FACTORY;
      stored_wiper_reg_b_r <= `DWC_NV_FACTORY;
    end else begin
      stored_wiper_reg_a_r <= stored_a_nxt;
      stored_wiper_reg_b_r <= stored_b_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata  = r_r.prdata;
  assign pslverr = r_r.pslverr & psel & penable;
  assign pready  = psel & penable;
  assign sda_o   = 1'b0;
  assign sda_oe  = link_oe;
  assign wiper_a = r_r.volatile_wiper_reg_a;
  assign wiper_b = r_r.volatile_wiper_reg_b;

endmodule // dwc_decoder

// ### test/dwc_decoder_asserts.sv
module dwc_decoder_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic [7:0]  wiper_a,
  input wire logic [7:0]  wiper_b
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************************************
  // port relations
  // ****************************************************************
  a_ready_access: assert property (pready == (psel && penable))
    else $error("pready not tied to access phase");
  a_err_unmapped: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
    else $error("unmapped access without error");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  a_rdata_idle: assert property (!psel && !$past(psel) |-> prdata == 32'h0)
    else $error("read data not cleared");
  a_err_mapped: assert property (psel && penable && paddr[1:0] == 2'b00 &&
    paddr <= 8'h14 |-> !pslverr)
    else $error("mapped access flagged as error");
  a_ack_pulls_low: assert property (sda_oe |-> !sda_o)
    else $error("ack drives data high");
  a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl)
    else $error("ack moved while clock high");
  a_ack_one_bit: assert property ($rose(sda_oe) |-> ##[1:20] !sda_oe)
    else $error("ack held too long");
  a_read_wiper: assert property (psel && penable && !pwrite &&
    paddr == 8'h00 |-> prdata == {24'h0, $past(wiper_a)})
    else $error("wiper read differs from output");
  a_wiper_on_scl: assert property ($changed({wiper_a, wiper_b}) |-> scl)
    else $error("wiper moved outside frame end");
endmodule // dwc_decoder_asserts

// ### test/dwc_i2c_master.sv
module dwc_i2c_master (
  output logic     scl,
  output logic     sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // bus master: clock stands high between frames
  // ****************************************************************
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic bit_io(input logic b, output logic s);
    scl = 1'b0;
    #16 sda_low = !b;
    #16 scl = 1'b1;
    #16 s = sda;
    #16;
  endtask
  // ack bits: 0 means acknowledged, unused bytes stay 1
  task automatic frame(input logic [23:0] f, input int nb,
                       output logic [2:0] ack);
    logic s;
    ack = 3'h7;
    // offset keeps scl edges off the pclk edges
    #1.7;
    sda_low = 1'b1;
    #32;
    for (int i = 0; i < nb; i++) begin
      for (int j = 7; j >= 0; j--)
        bit_io(f[8 * (2 - i) + j], s);
      bit_io(1'b1, ack[2 - i]);
    end
    scl = 1'b0;
    #16 sda_low = 1'b1;
    #16 scl = 1'b1;
    #32 sda_low = 1'b0;
    #32;
  endtask
endmodule // dwc_i2c_master

// ### test/dwc_decoder_test.sv
module dwc_decoder_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk, presetn, factory_rst_n, psel, penable, pwrite;
  logic        wp, scl, m_low, sda, pready, pslverr, sda_oe, en, bad, perr;
  logic [7:0]  paddr, wiper_a, wiper_b;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  ack;
  logic [7:0]  vol [2];
  logic [7:0]  sto [2];
  logic [7:0]  cmds [15] = '{8'h11, 8'h21, 8'h22, 8'h12, 8'h53, 8'h13,
    8'h61, 8'h52, 8'h23, 8'h62, 8'h51, 8'h63, 8'h71, 8'h14, 8'h13};
  int          err_count, checked, cyc, nfr;
  // pull-up on the shared data line
  assign sda = !(m_low || sda_oe);
  dwc_decoder u_dwc_decoder (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
    .write_protect(wp), .addr_strap_2(1'b1), .addr_strap_1(1'b0),
    .addr_strap_0(1'b1), .factory_rst_n(factory_rst_n),
    .wiper_a(wiper_a), .wiper_b(wiper_b));
  dwc_i2c_master u_dwc_i2c_master (.scl(scl), .sda_low(m_low), .sda(sda));
  // ****************************************************************
  // tasks
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic end_sim;
    if (err_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      end_sim;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic state_chk;
    apb(8'h00, 1'b0, 32'h0);
    chk(rd, {24'h0, vol[0]});
    chk({wiper_b, wiper_a}, {vol[1], vol[0]});
    apb(8'h04, 1'b0, 32'h0);
    chk(rd, {24'h0, vol[1]});
    apb(8'h08, 1'b0, 32'h0);
    chk(rd, {16'h0, sto[1], sto[0]});
    apb(8'h0C, 1'b0, 32'h0);
    chk(rd, {29'h0, bad, 1'b1, wp});
    apb(8'h10, 1'b0, 32'h0);
    chk(rd, {31'h0, en});
    apb(8'h14, 1'b0, 32'h0);
    chk(rd, {24'h0, nfr[7:0]});
  endtask
  // only a whole, addressed, enabled write frame acts
  task automatic run(input logic [7:0] a, c, d, input int nb);
    u_dwc_i2c_master.frame({a, c, d}, nb, ack);
    chk({29'h0, ack}, {29'h0, a[7:1] == 7'h2D ? 3'h7 >> nb : 3'h7});
    if (a == 8'h5A && nb == 3 && en) begin
      nfr++;
      bad = !(c[7:4] inside {4'h1, 4'h2, 4'h5, 4'h6} &&
              c[3:0] inside {4'h1, 4'h2, 4'h3});
      for (int i = 0; i < 2; i++)
        if (c[3:0] == 4'h3 || c[3:0] == 4'(i + 1))
          case (c[7:4])
            dwc_pkg::DWC_OP_WR_VOL:    vol[i] = wp ? sto[i] : d;
            dwc_pkg::DWC_OP_WR_STORED: if (!wp) sto[i] = d;
            dwc_pkg::DWC_OP_RESTORE:   vol[i] = sto[i];
            dwc_pkg::DWC_OP_SAVE:      if (!wp) sto[i] = vol[i];
            default: ;
          endcase
    end
    repeat (10) @(posedge pclk);
    state_chk;
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    presetn = 1'b0;
    factory_rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    wp = 1'b1;
    en = 1'b1;
    bad = 1'b0;
    vol = '{8'h80, 8'h80};
    sto = '{8'h80, 8'h80};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    factory_rst_n <= 1'b1;
    repeat (10) @(posedge pclk);
    state_chk;
    for (int p = 1; p >= 0; p--) begin
      wp <= !p[0];
      repeat (10) @(posedge pclk);
      for (int k = 0; k < 15; k++)
        run(8'h5A, cmds[k], 8'(k * 37 + p * 5 + 3), 3);
    end
    wp <= 1'b0;
    run(8'h5B, 8'h11, 8'hC3, 3);
    run(8'h58, 8'h11, 8'hC3, 3);
    run(8'h5A, 8'h11, 8'hC3, 2);
    apb(8'h10, 1'b1, 32'h0);
    en = 1'b0;
    run(8'h5A, 8'h11, 8'hC3, 3);
    apb(8'h10, 1'b1, 32'h1);
    en = 1'b1;
    chk({31'h0, perr}, 32'h0);
    apb(8'h18, 1'b0, 32'h0);
    chk({31'h0, perr}, 32'h1);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    vol = sto;
    nfr = 0;
    bad = 1'b0;
    repeat (10) @(posedge pclk);
    state_chk;
    end_sim;
  end
endmodule // dwc_decoder_test

bind dwc_decoder dwc_decoder_asserts u_dwc_decoder_asserts (.pclk(pclk),
  .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl(scl), .sda_o(sda_o), .sda_oe(sda_oe), .wiper_a(wiper_a),
  .wiper_b(wiper_b));
